// ===== port_a_gpio.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - eight pins, each input or output, same functions in every mode
// - direction register one bit per pin at FFD1; 1 drives, 0 input; the code decodes it at byte FF44 (index FFD1)
// - direction register is write-only; reads return all ones
// - direction cleared on reset and in hardware standby
// - direction kept in software standby; outputs keep driving
// - data register 8-bit read/write at FFD3 holds output values; the code decodes it at byte FF4C (index FFD3)
// - read of an output pin returns the data register bit
// - read of an input pin returns the pin level
// - data cleared on reset and hardware standby, kept in software standby
// - addresses decode on the low 16 bits of the bus address
// - pins also carry pattern, timer and dma functions
// - every pin: timer output, else dma output, else input, general or pattern output
// - pin 3 clock goes to timer when any prescale select is all ones
module port_a_gpio #(
  parameter int pins = 8
) (
  // clock, reset, enable
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  clk_en,
  input  wire logic                  hw_standby,
  input  wire logic                  sw_standby,
  // ahb-lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // pins
  input  wire logic [7:0]            pin_in,
  output logic      [7:0]            pin_out,
  output logic      [7:0]            pin_oe,
  // peripherals
  input  wire port_a_pkg::periph_s   periph,
  input  wire logic [14:0]           timer_prescale_select,
  output logic      [7:0]            pin_level_sync,
  output logic                       timer_ext_clock_in_d
);

  if (pins != 8) begin : g_bad
    $error("port_a_gpio serves exactly eight pins");
  end

  logic [7:0]  dir_reg;
  logic [7:0]  data_reg;
  logic [7:0]  sync1_reg;
  logic [7:0]  sync2_reg;
  logic        wr_pend_reg;
  logic        wr_dir_reg;
  logic        wr_data_reg;
  logic [31:0] hrdata_reg;
  logic [7:0]  out_reg;
  logic [7:0]  oe_reg;
  logic        tclk_reg;

  // address decode on the low half of haddr only
  wire         xfer     = hsel & hready & htrans[1];
  wire  [15:0] low_addr = haddr[15:0];
  wire         hit_dir  = low_addr == {port_a_pkg::dir_index[13:0], 2'b00};
  wire         hit_data = low_addr == {port_a_pkg::data_index[13:0], 2'b00};
  wire         standby_clear = hw_standby;

  // read mux: output pins show latch, input pins show synchronised level
  wire  [7:0]  port_read = (dir_reg & data_reg) | (~dir_reg & sync2_reg);
  wire  [31:0] read_word = (xfer & ~hwrite & hit_dir)  ? {24'h000000, port_a_pkg::dir_read_val} :
                           (xfer & ~hwrite & hit_data) ? {24'h000000, port_read} :
                           32'h00000000;

  // pin function select: timer wins, then dma, then pattern, then general port
  function automatic port_a_pkg::pin_drive_s pick(input logic [7:0] dir, input logic [7:0] dat,
                                                  input port_a_pkg::periph_s p);
    port_a_pkg::pin_drive_s r;
    r.oe  = p.timer_oe | p.dma_oe | dir;
    r.out = (p.timer_oe & p.timer_out) |
            (~p.timer_oe & p.dma_oe & p.dma_out) |
            (~p.timer_oe & ~p.dma_oe & dir & p.pattern_enable & p.pattern_out) |
            (~p.timer_oe & ~p.dma_oe & dir & ~p.pattern_enable & dat);
    return r;
  endfunction

  wire port_a_pkg::pin_drive_s drive = pick(dir_reg, data_reg, periph);

  // any of the five channels selecting the external clock
  logic [4:0] ext_sel;
  for (genvar i = 0; i < port_a_pkg::timer_chans; i++) begin : g_tpsc
    assign ext_sel[i] = timer_prescale_select[3*i +: 3] == port_a_pkg::prescale_ext;
  end

  // registers: hw standby clears like reset; sw standby just freezes writes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dir_reg  <= port_a_pkg::dir_reset;
      data_reg <= port_a_pkg::data_reset;
    end
    else if (clk_en)
    begin
      if (standby_clear)
      begin
        dir_reg  <= port_a_pkg::dir_reset;
        data_reg <= port_a_pkg::data_reset;
      end
      else if (wr_pend_reg & ~sw_standby)
      begin
        if (wr_dir_reg)
          dir_reg <= hwdata[7:0];
        if (wr_data_reg)
          data_reg <= hwdata[7:0];
      end // else holds through software standby
    end
  end

  // bus phases: write data arrives one cycle after its address
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_dir_reg  <= 1'b0;
      wr_data_reg <= 1'b0;
      hrdata_reg  <= 32'h00000000;
    end
    else if (clk_en)
    begin
      wr_pend_reg <= xfer & hwrite;
      wr_dir_reg  <= xfer & hwrite & hit_dir;
      wr_data_reg <= xfer & hwrite & hit_data;
      hrdata_reg  <= read_word;
    end
  end

  // synchroniser; first stage is read only by the second
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
    end
    else if (clk_en)
    begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  // registered pin drive and timer clock routing
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      out_reg  <= 8'h00;
      oe_reg   <= 8'h00;
      tclk_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      out_reg  <= drive.out;
      oe_reg   <= drive.oe;
      tclk_reg <= (|ext_sel) & sync2_reg[3];
    end
  end

  assign hrdata               = hrdata_reg;
  assign hreadyout            = 1'b1;
  assign hresp                = 1'b0;
  assign pin_out              = out_reg;
  assign pin_oe               = oe_reg;
  assign pin_level_sync       = sync2_reg;
  assign timer_ext_clock_in_d = tclk_reg;

endmodule
`default_nettype wire

// ===== port_a_pkg.sv
package port_a_pkg;
  // byte addresses of the two registers (low 16 bits of haddr)
  localparam logic [15:0] dir_addr      = 16'hff44;
  localparam logic [15:0] data_addr     = 16'hff4c;
  // printed offsets kept as register indices; byte address is index times four
  localparam logic [15:0] dir_index     = 16'hffd1;
  localparam logic [15:0] data_index    = 16'hffd3;
  localparam logic [7:0]  dir_reset     = 8'h00;
  localparam logic [7:0]  data_reset    = 8'h00;
  localparam logic [7:0]  dir_read_val  = 8'hff;
  localparam int          sync_stages   = 2;
  localparam int          addr_bits     = 16;
  localparam logic [2:0]  prescale_ext  = 3'h7;
  localparam int          timer_chans   = 5;

  // per-pin peripheral requests
  typedef struct packed {
    logic [7:0] timer_oe;
    logic [7:0] timer_out;
    logic [7:0] dma_oe;
    logic [7:0] dma_out;
    logic [7:0] pattern_enable;
    logic [7:0] pattern_out;
  } periph_s;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pin_drive_s;
endpackage

// ===== pin_model.sv
`timescale 1ns/100ps
`default_nettype none
// board side of the port: a driven pin reads back its own level, else the bench's level
module pin_model (
  input  wire logic [7:0] oe,
  input  wire logic [7:0] out,
  input  wire logic [7:0] ext,
  output logic      [7:0] pins
);
  assign pins = (oe & out) | (~oe & ext);
endmodule
`default_nettype wire

// ===== port_a_sva.sv
`timescale 1ns/100ps
`default_nettype none
module port_a_sva (
  // bus
  input wire logic        hclk, hresetn, hsel, hready, hwrite, hreadyout, hresp,
  input wire logic [1:0]  htrans,
  input wire logic [31:0] haddr, hrdata,
  // pins and modes
  input wire logic [7:0]  pin_in, pin_out, pin_oe, pin_level_sync,
  input wire logic        clk_en, hw_standby, sw_standby,
  input wire port_a_pkg::periph_s periph
);
  localparam logic [15:0] dir_a = 16'(port_a_pkg::dir_index << 2);
  localparam logic [15:0] dat_a = 16'(port_a_pkg::data_index << 2);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_take;
    hsel && hready && htrans[1] && !hwrite && clk_en;
  endsequence
  sequence sw_calm;
    sw_standby && !hw_standby && $stable(periph);
  endsequence
  // zero wait states, so the master never stalls
  ready_okay_a: assert property (hreadyout && !hresp) else $error("bus stalled or error");
  idle_zero_a: assert property (clk_en && !(hsel && hready && htrans[1]) |=> hrdata == 32'h0)
    else $error("read data outside a read");
  dir_read_a: assert property (rd_take ##0 haddr[15:0] == dir_a |=> hrdata == 32'h000000ff)
    else $error("direction read not all ones");
  unmapped_a: assert property (rd_take ##0 haddr[15:0] != dir_a && haddr[15:0] != dat_a
    |=> hrdata == 32'h0) else $error("unmapped read not zero");
  sync_chain_a: assert property ($past(hresetn, 2) && $past(clk_en) && $past(clk_en, 2)
    |-> pin_level_sync == $past(pin_in, 2)) else $error("synchroniser depth wrong");
  hw_clear_a: assert property (hw_standby && clk_en |-> ##2
    (pin_oe & ~$past(periph.timer_oe | periph.dma_oe)) == 8'h00) else $error("standby clear");
  timer_pri_a: assert property (clk_en |=> (pin_oe & $past(periph.timer_oe)) == $past(periph.timer_oe)
    && ((pin_out ^ $past(periph.timer_out)) & $past(periph.timer_oe)) == 8'h00)
    else $error("timer output lost");
  sw_hold_a: assert property (sw_calm ##1 sw_calm |=> $stable(pin_oe) && $stable(pin_out))
    else $error("pins moved in soft standby");
endmodule
bind port_a_gpio port_a_sva u_sva (.*);
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/100ps
`default_nettype none
`define chk(n, e, s) begin n_compared++; if ((s) !== (e)) begin fails++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module testbench;
  logic                hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, hw_sb = 1'b0, sw_sb = 1'b0;
  logic [1:0]          htrans = 2'h0;
  logic [31:0]         haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [7:0]          ext = 8'h00, pin_in, pin_out, pin_oe, d, v, e;
  logic [14:0]         psel = 15'h0;
  logic                hready, hresp, tclk;
  logic                en = 1'b1;
  port_a_pkg::periph_s periph = '0;
  int                  fails = 0, n_compared = 0, cyc = 0;
  localparam logic [31:0] dir_a = 32'(port_a_pkg::dir_index) << 2;
  localparam logic [31:0] dat_a = 32'(port_a_pkg::data_index) << 2;
  always #5 hclk = ~hclk;
  port_a_gpio u_port_a_gpio (.hclk(hclk), .hresetn(hresetn), .clk_en(en), .hw_standby(hw_sb),
    .sw_standby(sw_sb), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
    .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .periph(periph),
    .timer_prescale_select(psel), .pin_level_sync(), .timer_ext_clock_in_d(tclk));
  pin_model u_pin_model (.oe(pin_oe), .out(pin_out), .ext(ext), .pins(pin_in));
  // one single transfer; read data is taken at the edge closing the data phase
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    htrans <= 2'h2; hwrite <= w; haddr <= a;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0; hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc > 3000)
    begin
      fails++;
      wrap_up();
    end
  end
  initial
  begin
    void'($urandom(32'h8a7cb694));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1; ext <= 8'h5a;
    repeat (4) @(posedge hclk);
    xfer(1'b0, dat_a, 32'h0, r);
    `chk("reset read", 32'h5a, r)
    `chk("reset oe", 8'h00, pin_oe)
    repeat (16)
    begin
      d = 8'($urandom);
      v = 8'($urandom);
      e = 8'($urandom);
      xfer(1'b1, {16'($urandom), dir_a[15:0]}, {24'($urandom), d}, r);
      xfer(1'b1, dat_a, {24'h0, v}, r);
      ext <= e;
      repeat (3) @(posedge hclk);
      xfer(1'b0, dat_a, 32'h0, r);
      `chk("port read", {24'h0, (d & v) | (~d & e)}, r)
      `chk("drive", {d, d & v}, {pin_oe, pin_out & d})
      xfer(1'b0, dir_a, 32'h0, r);
      `chk("dir read", 32'hff, r)
    end
    xfer(1'b0, dat_a + 32'h4, 32'h0, r);
    `chk("unmapped", 32'h0, r)
    sw_sb <= 1'b1;
    xfer(1'b1, dat_a, {24'h0, ~v}, r);
    xfer(1'b1, dir_a, 32'h0, r);
    `chk("soft hold", {d, d & v}, {pin_oe, pin_out & d})
    sw_sb <= 1'b0; hw_sb <= 1'b1;
    @(posedge hclk) hw_sb <= 1'b0;
    repeat (2) @(posedge hclk);
    `chk("hard oe", 8'h00, pin_oe)
    xfer(1'b1, dir_a, 32'hff, r);
    xfer(1'b0, dat_a, 32'h0, r);
    `chk("hard data", 32'h0, r)
    // timer wins on pin 7, pattern drives the rest
    e = 8'($urandom);
    periph <= '{8'h80, 8'h80, 8'h00, 8'h00, 8'hff, e};
    psel <= 15'h01c0;
    repeat (6) @(posedge hclk);
    `chk("alt out", {8'hff, 8'h80 | e}, {pin_oe, pin_out})
    `chk("ext clock", e[3], tclk)
    // enable low freezes the pin drive although the requests go away
    en <= 1'b0;
    periph <= '0;
    repeat (3) @(posedge hclk);
    `chk("frozen", {8'hff, 8'h80 | e}, {pin_oe, pin_out})
    en <= 1'b1;
    wrap_up();
  end
endmodule
`default_nettype wire
